// *** src/prn_sender.sv ***
/*
 * Parallel printer output port: bytes from the host queue are strobed out
 * to a printer with a busy handshake, a block at a time.
 * Assumes host bytes arrive synchronous to clk, last byte of a block marked;
 * printer busy and present lines are already synchronous.
 */
`timescale 1ns/10ps
`include "prn_port_defines.svh"

// Function
// - Print requests are ignored while the printer-present input is low.
// - Data outputs are positive logic and rest at zero between transfers.
// - Strobe idles high and goes low for one pulse per byte.
// - A byte starts only while busy is low, data first, then the strobe.
// - After a strobe, busy seen and then fallen releases the next byte at once.
// - If busy does not rise within 200 us of a byte, the byte counts as taken.
// - With no busy at all, bytes leave about one per 280 us.
// - Completion is reported to the host after the whole block is accepted.
module prn_sender
    import prn_port_pkg::*;
#(
    parameter int SETUP_CYC   = `SETUP_CYC,
    parameter int STROBE_CYC  = `STROBE_CYC,
    parameter int WAIT_CYC    = `BUSY_WAIT_CYC,
    parameter int GAP_CYC     = `BYTE_GAP_CYC - `BUSY_WAIT_CYC - `SETUP_CYC - `STROBE_CYC,
    parameter int BLOCK_CYC   = `BLOCK_LIMIT_CYC,
    parameter int FIFO_DEPTH  = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Host byte stream
    input  wire logic       hostValid,
    output logic            hostReady,
    input  wire logic [7:0] hostData,
    input  wire logic       hostLast,
    // Host result
    output logic            printDone,
    output logic            printTimeout,
    // Printer pins
    input  wire logic       printerPresent,
    input  wire logic       printerBusy,
    output logic [7:0]      printData,
    output logic            dataStrobe_n
);
    localparam int CW = 32;

    prnState_e       state_ff, nxt_state;
    logic [CW-1:0]   timer_ff;
    logic [CW-1:0]   blockTimer_ff;
    logic            inBlock_ff;
    logic            lastByte_ff;
    logic [7:0]      printData_ff;
    logic            strobe_n_ff;
    logic            done_ff;
    logic            tmo_ff;
    logic            qValid;
    logic            qReady;
    logic            fReady;
    prnWord_s        qWord;
    prnWord_s        hostWord;
    logic            hostReady_ff;
    wire             hostTake = hostValid && hostReady_ff;

    // Requests are only admitted while a printer is present
    assign hostWord  = '{last: hostLast, data: hostData};

    // Ready is a flop; it drops for one cycle after each take so that it never
    // runs ahead of the FIFO count. Half rate is plenty against a printer.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hostReady_ff <= 1'b0;
        end else begin
            hostReady_ff <= printerPresent && fReady && !hostTake;
        end
    end

    prn_fifo #(.WIDTH($bits(prnWord_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .inValid  (hostTake),
        .inReady  (fReady),
        .inData   (hostWord),
        .outValid (qValid),
        .outReady (qReady),
        .outData  (qWord)
    );

    // Decoded conditions for the sequencer
    wire timerDone  = (timer_ff == '0);
    wire blockOver  = inBlock_ff && (blockTimer_ff == '0);
    wire canStart   = qValid && printerPresent && !printerBusy;
    assign qReady   = (state_ff == ST_IDLE) && canStart && !blockOver;

    // Next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:      if (canStart && !blockOver) nxt_state = ST_SETUP;
            ST_SETUP:     if (timerDone) nxt_state = ST_STROBE;
            ST_STROBE:    if (timerDone) nxt_state = ST_WAIT_BUSY;
            ST_WAIT_BUSY: begin
                if (printerBusy) nxt_state = ST_WAIT_LOW;
                else if (timerDone) nxt_state = ST_GAP;
            end
            ST_WAIT_LOW:  if (!printerBusy) nxt_state = ST_IDLE;
            ST_GAP:       if (timerDone) nxt_state = ST_IDLE;
            default:      nxt_state = ST_IDLE;
        endcase
        if (blockOver && state_ff != ST_STROBE) nxt_state = ST_IDLE;
    end

    // Sequencer, per-state timer and output pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= ST_IDLE;
            timer_ff     <= '0;
            printData_ff <= `DATA_IDLE;
            strobe_n_ff  <= 1'b1;
            lastByte_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff != nxt_state) begin
                case (nxt_state)
                    ST_SETUP:     timer_ff <= CW'(SETUP_CYC - 1);
                    ST_STROBE:    timer_ff <= CW'(STROBE_CYC - 1);
                    ST_WAIT_BUSY: timer_ff <= CW'(WAIT_CYC - 1);
                    ST_GAP:       timer_ff <= CW'(GAP_CYC - 1);
                    default:      timer_ff <= '0;
                endcase
            end else if (!timerDone) begin
                timer_ff <= timer_ff - 1'b1;
            end
            if (qReady) begin
                printData_ff <= qWord.data;
                lastByte_ff  <= qWord.last;
            end else if (nxt_state == ST_IDLE) begin
                printData_ff <= `DATA_IDLE;
            end
            strobe_n_ff <= (nxt_state != ST_STROBE);
        end
    end

    // Block watchdog and host result pulses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inBlock_ff    <= 1'b0;
            blockTimer_ff <= '0;
            done_ff       <= 1'b0;
            tmo_ff        <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            tmo_ff  <= 1'b0;
            if (blockOver) begin
                // A strobe in flight is finished first; the timer rests at zero meanwhile
                if (state_ff != ST_STROBE) begin
                    inBlock_ff <= 1'b0;
                    tmo_ff     <= 1'b1;
                end
            end else if (qReady && !inBlock_ff) begin
                inBlock_ff    <= 1'b1;
                blockTimer_ff <= CW'(BLOCK_CYC - 1);
            end else if (inBlock_ff) begin
                blockTimer_ff <= blockTimer_ff - 1'b1;
                if (lastByte_ff && state_ff != ST_IDLE && nxt_state == ST_IDLE) begin
                    inBlock_ff <= 1'b0;
                    done_ff    <= 1'b1;
                end
            end
        end
    end

    assign hostReady    = hostReady_ff;
    assign printData    = printData_ff;
    assign dataStrobe_n = strobe_n_ff;
    assign printDone    = done_ff;
    assign printTimeout = tmo_ff;

    // Checks
    sequence s_strobeLow;
        !dataStrobe_n [*2];
    endsequence
    property p_idleData;
        @(posedge clk) disable iff (!reset_n) (state_ff == ST_IDLE) |-> printData == `DATA_IDLE;
    endproperty
    a_idleData: assert property (p_idleData) else $error("data not null at idle");
    property p_strobeWidth;
        @(posedge clk) disable iff (!reset_n) $fell(dataStrobe_n) |-> s_strobeLow;
    endproperty
    a_strobeWidth: assert property (p_strobeWidth) else $error("strobe too short");
    property p_setupFirst;
        @(posedge clk) disable iff (!reset_n) $fell(dataStrobe_n) |-> $stable(printData);
    endproperty
    a_setupFirst: assert property (p_setupFirst) else $error("data moved at strobe");
    property p_noStartBusy;
        @(posedge clk) disable iff (!reset_n)
            (state_ff == ST_SETUP && $past(state_ff) == ST_IDLE) |-> !$past(printerBusy) && $past(printerPresent);
    endproperty
    a_noStartBusy: assert property (p_noStartBusy) else $error("start while busy or absent");
    property p_absentRefuse;
        @(posedge clk) disable iff (!reset_n) !printerPresent |=> !hostReady;
    endproperty
    a_absentRefuse: assert property (p_absentRefuse) else $error("request open while absent");
    property p_busyRelease;
        @(posedge clk) disable iff (!reset_n) (state_ff == ST_WAIT_LOW && !printerBusy && !blockOver)
            |=> state_ff == ST_IDLE;
    endproperty
    a_busyRelease: assert property (p_busyRelease) else $error("no release after busy");
    property p_waitBound;
        @(posedge clk) disable iff (!reset_n) (state_ff == ST_WAIT_BUSY) |-> timer_ff < CW'(WAIT_CYC);
    endproperty
    a_waitBound: assert property (p_waitBound) else $error("busy wait too long");
    property p_gapAfterWait;
        @(posedge clk) disable iff (!reset_n)
            (state_ff == ST_WAIT_BUSY && timerDone && !printerBusy && !blockOver) |=> state_ff == ST_GAP;
    endproperty
    a_gapAfterWait: assert property (p_gapAfterWait) else $error("no gap after silent wait");
    property p_doneExcl;
        @(posedge clk) disable iff (!reset_n) !(printDone && printTimeout);
    endproperty
    a_doneExcl: assert property (p_doneExcl) else $error("done and timeout together");
    property p_timeout;
        @(posedge clk) disable iff (!reset_n) (blockOver && state_ff != ST_STROBE) |=> printTimeout && !inBlock_ff;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not reported");
endmodule : prn_sender

// *** src/prn_port_defines.svh ***
/*
 * Timing counts and reset values for the parallel printer sender.
 * Assumes a 25 MHz system clock (40 ns period).
 */
`ifndef PRN_PORT_DEFINES_SVH
`define PRN_PORT_DEFINES_SVH

`define CLK_PERIOD_NS      40
`define BUSY_WAIT_US       200
`define BUSY_WAIT_CYC      ((`BUSY_WAIT_US * 1000) / `CLK_PERIOD_NS)
`define BYTE_GAP_US        280
`define BYTE_GAP_CYC       ((`BYTE_GAP_US * 1000) / `CLK_PERIOD_NS)
`define BLOCK_LIMIT_S      4
// Cycles per second first, so the product stays inside a 32-bit int
`define BLOCK_LIMIT_CYC    (`BLOCK_LIMIT_S * (1000000000 / `CLK_PERIOD_NS))
`define BLOCK_LEN          40
`define SETUP_CYC          25
`define STROBE_CYC         50
`define DATA_IDLE          8'h00

`endif

// *** src/prn_port_pkg.sv ***
/*
 * Types shared by the printer sender and its FIFO.
 * Assumes the defines header is available on the include path.
 */
package prn_port_pkg;

    // Byte with end-of-block marker
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } prnWord_s;

    // Sender sequencing
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_WAIT_BUSY,
        ST_WAIT_LOW,
        ST_GAP
    } prnState_e;

endpackage : prn_port_pkg

// *** src/prn_fifo.sv ***
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; reads and writes may happen in the same cycle.
 */
`timescale 1ns/10ps
module prn_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    wire              doWr = inValid && inReady;
    wire              doRd = outValid && outReady;

    // Full and empty from a true occupancy count
    assign inReady  = (count_ff != (AW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData  = mem[rdPtr_ff];

    // Storage array
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doWr) wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            if (doRd) rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            count_ff <= count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule : prn_fifo

// *** tb/prn_printer_model.sv ***
/*
 * Behavioural printer on the far side of the parallel port.
 * Assumes it sees the port pins on the sender's clock.
 */
`timescale 1ns/10ps
module prn_printer_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Port pins
    input  wire logic [7:0] printData,
    input  wire logic       dataStrobe_n,
    output logic            printerBusy,
    // Bench controls
    input  wire logic [7:0] busyLen,
    input  wire logic       holdBusy
);
    logic [7:0] rxQ[$];
    int         lowW;
    int         busyCnt;
    logic       strobePrev;
    localparam int BUSY_MIN_CYC = 1260; // Just over 50 us of 40 ns cycles

    // Latch a byte on the strobe's trailing edge, then answer busy; busyLen of
    // zero means a printer that never raises busy. Non-blocking, so busy never
    // races the sender's sampling edge.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt    <= 0;
            lowW       <= 0;
            strobePrev <= 1'b1;
        end else begin
            if (!dataStrobe_n) lowW <= strobePrev ? 1 : lowW + 1;
            if (dataStrobe_n && !strobePrev) begin
                rxQ.push_back(printData);
                busyCnt <= (busyLen == 8'h00) ? 0 : BUSY_MIN_CYC + int'(busyLen);
            end else if (busyCnt > 0) begin
                busyCnt <= busyCnt - 1; // Always drops again, so a block finishes in time
            end
            strobePrev <= dataStrobe_n;
        end
    end

    // Busy is a driven level, never left floating
    assign printerBusy = holdBusy || (busyCnt > 0);
endmodule : prn_printer_model

// *** tb/test_parallel_printer_port_sender.sv ***
/*
 * Self-checking bench for the parallel printer sender.
 * Assumes shortened timing parameters; a printer model answers busy.
 */
`timescale 1ns/10ps
module test_parallel_printer_port_sender;
    logic       clk, reset_n, hostValid, hostLast, printerPresent, holdBusy;
    logic [7:0] hostData, busyLen;
    logic       hostReady, printDone, printTimeout, printerBusy, dataStrobe_n, strobePrev;
    logic [7:0] printData;
    int         mismatches, n_compared, cyc;
    int         fallAt[$];

    prn_sender #(.SETUP_CYC(2), .STROBE_CYC(3), .WAIT_CYC(20), .GAP_CYC(5), .BLOCK_CYC(15000)) dut (
        .clk(clk), .reset_n(reset_n), .hostValid(hostValid), .hostReady(hostReady),
        .hostData(hostData), .hostLast(hostLast), .printDone(printDone), .printTimeout(printTimeout),
        .printerPresent(printerPresent), .printerBusy(printerBusy), .printData(printData),
        .dataStrobe_n(dataStrobe_n));
    prn_printer_model model (
        .clk(clk), .reset_n(reset_n), .printData(printData), .dataStrobe_n(dataStrobe_n),
        .printerBusy(printerBusy), .busyLen(busyLen), .holdBusy(holdBusy));

    // Clock and strobe-fall timestamps
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (strobePrev && !dataStrobe_n) fallAt.push_back(cyc);
        strobePrev = dataStrobe_n;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Offer one byte and hold it until the edge that takes it
    task automatic push(input logic [7:0] d, input logic l);
        int k;
        @(posedge clk);
        #1;
        hostValid = 1'b1;
        hostData  = d;
        hostLast  = l;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!hostReady && k < 5000);
        chk("push taken", 16'h0001, {15'h0, hostReady});
        #1 hostValid = 1'b0;
    endtask : push

    task automatic wait_end(input int lim, output int n, output logic d, output logic t);
        n = 0;
        d = 1'b0;
        t = 1'b0;
        while (!d && !t && n < lim) begin
            @(posedge clk);
            d = printDone;
            t = printTimeout;
            n++;
        end
    endtask : wait_end

    task automatic t_absent;
        printerPresent = 1'b0;
        hostValid = 1'b1;
        repeat (4) @(posedge clk);
        chk("ready absent", 16'h0000, {15'h0, hostReady});
        #1 hostValid = 1'b0;
        repeat (40) @(posedge clk);
        chk("no strobe absent", 16'h0000, model.rxQ.size());
        #1 printerPresent = 1'b1;
        $display("test absent done");
    endtask : t_absent

    // Short busy after each byte, whole block completes
    task automatic t_busy;
        int n;
        logic d, t;
        busyLen = 8'h0A;
        push(8'hA5, 1'b0);
        push(8'h3C, 1'b0);
        push(8'h81, 1'b1);
        wait_end(5000, n, d, t);
        chk("done", 16'h0001, {15'h0, d});
        chk("bytes", 16'h0003, model.rxQ.size());
        chk("byte0", 16'h00A5, model.rxQ[0]);
        chk("byte2", 16'h0081, model.rxQ[2]);
        chk("strobe width", 16'h0003, model.lowW);
        @(posedge clk);
        chk("data idle", 16'h0000, printData);
        chk("strobe idle", 16'h0001, {15'h0, dataStrobe_n});
        $display("test busy done");
    endtask : t_busy

    // Printer never answers busy: each byte is assumed taken
    task automatic t_nobusy;
        int n, g;
        logic d, t;
        busyLen = 8'h00;
        fallAt.delete();
        push(8'h11, 1'b0);
        push(8'h22, 1'b1);
        wait_end(500, n, d, t);
        chk("done nobusy", 16'h0001, {15'h0, d});
        g = fallAt[1] - fallAt[0];
        chk("byte spacing", 16'h0001, {15'h0, g >= 30 && g <= 34});
        $display("test nobusy done");
    endtask : t_nobusy

    // Block with no last marker must time out
    task automatic t_timeout;
        int n;
        logic d, t;
        push(8'h5A, 1'b0);
        wait_end(15100, n, d, t);
        chk("timeout", 16'h0001, {15'h0, t});
        chk("no done", 16'h0000, {15'h0, d});
        chk("not early", 16'h0001, {15'h0, n >= 14990});
        $display("test timeout done");
    endtask : t_timeout

    // Busy held: the queue fills and refuses, then drains in order
    task automatic t_full;
        int n;
        logic d, t;
        holdBusy = 1'b1;
        busyLen  = 8'h04;
        model.rxQ.delete();
        for (int i = 0; i < 8; i++) push(8'(i * 17 + 1), i == 7);
        @(posedge clk);
        #1 hostValid = 1'b1;
        repeat (3) @(posedge clk);
        chk("ready full", 16'h0000, {15'h0, hostReady});
        chk("held by busy", 16'h0000, model.rxQ.size());
        #1 hostValid = 1'b0;
        holdBusy = 1'b0;
        wait_end(12000, n, d, t);
        chk("done full", 16'h0001, {15'h0, d});
        chk("drained", 16'h0008, model.rxQ.size());
        for (int i = 0; i < 8; i++) chk("order", 16'(i * 17 + 1), model.rxQ[i]);
        $display("test full done");
    endtask : t_full

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Watchdog well past the longest expected run
    initial begin
        #(40 * 60000);
        mismatches++;
        end_sim();
    end

    initial begin
        {reset_n, hostValid, hostLast, holdBusy} = 4'h0;
        {hostData, busyLen} = 16'h0000;
        printerPresent = 1'b1;
        strobePrev = 1'b1;
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        chk("reset data", 16'h0000, printData);
        chk("reset strobe", 16'h0001, {15'h0, dataStrobe_n});
        t_absent();
        t_busy();
        t_nobusy();
        t_timeout();
        t_full();
        end_sim();
    end
endmodule : test_parallel_printer_port_sender
